// File: pkg/dscp_pkg.sv
// constants and types of the converter serial control port
package dscp_pkg;
  localparam int         FRAME_BITS    = 32;
  localparam logic [5:0] CNT_RESET     = 6'h00;
  localparam logic [5:0] CNT_LAST      = 6'h1f;
  localparam logic [5:0] CNT_FULL      = 6'h20;
  localparam logic [6:0] ADDR_NOP      = 7'h00;
  localparam logic [6:0] ADDR_CODE     = 7'h01;
  localparam logic [6:0] ADDR_CFG1     = 7'h02;
  localparam logic [6:0] ADDR_CLEAR    = 7'h03;
  localparam logic [6:0] ADDR_TRIG     = 7'h04;
  localparam logic [6:0] ADDR_STAT     = 7'h05;
  localparam logic [6:0] ADDR_CFG2     = 7'h06;
  localparam int         CFG1_UPD_MODE = 14;
  localparam int         CFG1_FAST_OUT = 13;
  localparam int         CFG1_CHAIN_DIS = 11;
  localparam int         CFG1_PDN      = 4;
  localparam int         TRIG_SW_CLEAR = 5;
  localparam int         TRIG_SW_RESET = 6;
  localparam int         TRIG_CAL      = 8;
  localparam int         STAT_ALARM    = 12;
  localparam int         CFG2_DEGLITCH_DISABLE  = 7;
  localparam int         CFG2_RATE_LSB = 4;
  localparam logic [23:0] CFG1_RESET   = 24'h004c80;
  localparam logic [23:0] CFG1_WMASK   = 24'h8c7fd0;
  localparam logic [23:0] CFG2_RESET   = 24'h000000;
  localparam logic [23:0] CFG2_WMASK   = 24'h0000f0;
  localparam logic [19:0] CODE_RESET   = 20'h00000;
  localparam logic [19:0] CLEAR_RESET  = 20'h00000;
  localparam logic [31:0] WORD_RESET   = 32'h00000000;
  typedef struct packed {
    logic        rd;
    logic [6:0]  addr;
    logic [19:0] data;
    logic [3:0]  pad;
  } dscp_frame_type;
endpackage

// File: rtl/dscp_port.sv
// serial control port with register file and output latch
`timescale 1ns/1ns
module dscp_port
  import dscp_pkg::*;
(
  input  wire logic        SYS_CLK_I,
  input  wire logic        RST_N_I,
  input  wire logic        CE_I,
  input  wire logic        SCLK_I,
  input  wire logic        SYNC_N_I,
  input  wire logic        SDI_I,
  input  wire logic        UPDATE_STROBE_N_I,
  input  wire logic        CLEAR_PIN_N_I,
  input  wire logic        ALARM_FLAG_I,
  output logic             SDO_O,
  output logic [19:0]      DAC_CODE_O,
  output logic             CLEAR_MODE_O,
  output logic             FAST_OUTPUT_EN_O,
  output logic             POWER_DOWN_O,
  output logic             DEGLITCH_DIS_O,
  output logic [2:0]       DEGLITCH_RATE_O,
  output logic             CAL_START_O
);
  import dscp_pkg::*;

  logic [5:0]     bit_cnt;
  logic [31:0]    in_sr;
  logic [31:0]    out_sr;
  logic [31:0]    word_cap;
  logic           frame_ok;
  logic           ev_tog;
  logic           sclk_rst_n;
  logic [31:0]    rd_word;
  logic [23:0]    rd_view;
  logic           sync_s1;
  logic           sync_s2;
  logic           sync_s3;
  logic           clr_s1;
  logic           clr_s2;
  logic           upd_s1;
  logic           upd_s2;
  logic           upd_s3;
  logic           tog_s1;
  logic           tog_s2;
  logic           tog_s3;
  logic           alm_s1;
  logic           alm_s2;
  logic [23:0]    cfg1;
  logic [23:0]    cfg2;
  logic [19:0]    clear_code;
  logic [19:0]    buffer;
  logic [19:0]    dac;
  logic           clear_mode;
  logic           cal_start;
  dscp_frame_type fr;
  dscp_frame_type cap;
  logic           commit;
  logic           wr;
  logic           ev32;
  logic           upd_rise;
  logic           wr_code;
  logic           ev32_code;
  logic           swclr;
  logic           swrst;
  logic           mode;
  logic           chain_dis;

  // link side: sync high holds the counter in reset, so stray clocks count nothing
  assign sclk_rst_n = RST_N_I & ~SYNC_N_I;

  always_ff @(negedge SCLK_I or negedge sclk_rst_n) begin
    if (!sclk_rst_n) begin
      bit_cnt <= CNT_RESET;
    end else if (bit_cnt != CNT_FULL) begin
      bit_cnt <= bit_cnt + 6'h01;
    end
  end

  always_ff @(negedge SCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      in_sr <= WORD_RESET;
    end else if (!SYNC_N_I) begin
      in_sr <= {in_sr[30:0], SDI_I};
    end
  end

  // 32nd falling edge snapshot; an event toggle tells the system side
  always_ff @(negedge SCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      frame_ok <= 1'b0;
      word_cap <= WORD_RESET;
      ev_tog   <= 1'b0;
    end else if (!SYNC_N_I) begin
      if (bit_cnt == CNT_LAST) begin
        frame_ok <= 1'b1;
        word_cap <= {in_sr[30:0], SDI_I};
        ev_tog   <= ~ev_tog;
      end else if (bit_cnt == CNT_RESET) begin
        frame_ok <= 1'b0;
      end
    end
  end

  // rd_word is static during a frame, sampled at the first rising edge
  always_ff @(posedge SCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      out_sr <= WORD_RESET;
      SDO_O  <= 1'b0;
    end else if (!SYNC_N_I) begin
      if (bit_cnt == CNT_RESET) begin
        SDO_O  <= rd_word[31];
        out_sr <= {rd_word[30:0], 1'b0};
      end else if (bit_cnt == CNT_FULL) begin
        SDO_O  <= in_sr[31];
      end else begin
        SDO_O  <= out_sr[31];
        out_sr <= {out_sr[30:0], 1'b0};
      end
    end
  end

  // system side synchronisers
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      {sync_s1, sync_s2, sync_s3} <= 3'h7;
      {clr_s1, clr_s2}            <= 2'h3;
      {upd_s1, upd_s2, upd_s3}    <= 3'h7;
      {tog_s1, tog_s2, tog_s3}    <= 3'h0;
      {alm_s1, alm_s2}            <= 2'h0;
    end else if (CE_I) begin
      {sync_s1, sync_s2, sync_s3} <= {SYNC_N_I, sync_s1, sync_s2};
      {clr_s1, clr_s2}            <= {CLEAR_PIN_N_I, clr_s1};
      {upd_s1, upd_s2, upd_s3}    <= {UPDATE_STROBE_N_I, upd_s1, upd_s2};
      {tog_s1, tog_s2, tog_s3}    <= {ev_tog, tog_s1, tog_s2};
      {alm_s1, alm_s2}            <= {ALARM_FLAG_I, alm_s1};
    end
  end

  // link words are stable here: registers only shift while sync is low
  assign fr        = dscp_frame_type'(in_sr);
  assign cap       = dscp_frame_type'(word_cap);
  assign commit    = sync_s2 & ~sync_s3 & frame_ok;
  assign wr        = commit & ~fr.rd;
  assign ev32      = tog_s2 ^ tog_s3;
  assign upd_rise  = upd_s2 & ~upd_s3;
  assign mode      = cfg1[CFG1_UPD_MODE];
  assign chain_dis = cfg1[CFG1_CHAIN_DIS];
  assign wr_code   = wr & (fr.addr == ADDR_CODE);
  assign ev32_code = ev32 & ~cap.rd & (cap.addr == ADDR_CODE);
  assign swclr     = wr & (fr.addr == ADDR_TRIG) & in_sr[TRIG_SW_CLEAR];
  assign swrst     = wr & (fr.addr == ADDR_TRIG) & in_sr[TRIG_SW_RESET];

  // configuration registers; masks keep reserved bits and low nibble zero
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      cfg1       <= CFG1_RESET;
      cfg2       <= CFG2_RESET;
      clear_code <= CLEAR_RESET;
    end else if (CE_I) begin
      if (swrst) begin
        cfg1       <= CFG1_RESET;
        cfg2       <= CFG2_RESET;
        clear_code <= CLEAR_RESET;
      end else if (wr) begin
        if (fr.addr == ADDR_CFG1) begin
          cfg1 <= in_sr[23:0] & CFG1_WMASK;
        end
        if (fr.addr == ADDR_CFG2) begin
          cfg2 <= in_sr[23:0] & CFG2_WMASK;
        end
        if (fr.addr == ADDR_CLEAR) begin
          clear_code <= fr.data;
        end
      end
    end
  end

  // buffer, output latch and clear mode
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      buffer     <= CODE_RESET;
      dac        <= CODE_RESET;
      clear_mode <= 1'b0;
    end else if (CE_I) begin
      if (swrst) begin
        buffer     <= CODE_RESET;
        dac        <= CODE_RESET;
        clear_mode <= 1'b0;
      end else if (!clr_s2) begin
        buffer     <= clear_code;
        dac        <= clear_code;
        clear_mode <= 1'b1;
      end else if (swclr) begin
        buffer     <= clear_code;
        dac        <= clear_code;
        clear_mode <= 1'b0;
      end else begin
        if (wr) begin
          clear_mode <= 1'b0;
        end
        if (wr_code) begin
          buffer <= fr.data;
        end else if (ev32_code && chain_dis) begin
          buffer <= cap.data;
        end
        // a write that ends clear mode also lands when the 32nd edge was skipped
        if (!mode && wr_code && (!chain_dis || clear_mode)) begin
          dac <= fr.data;
        end else if (!mode && chain_dis && ev32_code && !clear_mode) begin
          dac <= cap.data;
        end else if (mode && upd_rise && !clear_mode) begin
          dac <= buffer;
        end
      end
    end
  end

  function automatic logic [23:0] reg_view(input logic [6:0] a);
    logic [23:0] v;
    v = 24'h000000;
    unique case (a)
      ADDR_CODE:  v = {dac, 4'h0};
      ADDR_CFG1:  v = cfg1;
      ADDR_CLEAR: v = {clear_code, 4'h0};
      ADDR_STAT:  v[STAT_ALARM] = alm_s2;
      ADDR_CFG2:  v = cfg2;
      default:    v = 24'h000000;
    endcase
    return v;
  endfunction

  assign rd_view = reg_view(fr.addr);

  // read word latched at the read frame's end, shifted out next frame
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      rd_word <= WORD_RESET;
    end else if (CE_I) begin
      if (commit && fr.rd) begin
        rd_word <= {1'b1, fr.addr, rd_view[23:4], 4'h0};
      end else if (commit) begin
        rd_word <= WORD_RESET;
      end
    end
  end

  // one-cycle start pulse; calibration itself lives outside this port
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      cal_start <= 1'b0;
    end else if (CE_I) begin
      cal_start <= wr & (fr.addr == ADDR_TRIG) & in_sr[TRIG_CAL];
    end
  end

  assign DAC_CODE_O       = dac;
  assign CLEAR_MODE_O     = clear_mode;
  assign FAST_OUTPUT_EN_O = cfg1[CFG1_FAST_OUT];
  assign POWER_DOWN_O     = cfg1[CFG1_PDN];
  assign DEGLITCH_DIS_O   = cfg2[CFG2_DEGLITCH_DISABLE];
  assign DEGLITCH_RATE_O  = cfg2[CFG2_RATE_LSB +: 3];
  assign CAL_START_O      = cal_start;

  cnt_bound_a: assert property (@(negedge SCLK_I) disable iff (!RST_N_I)
    bit_cnt <= CNT_FULL) else $error("bit counter beyond frame");

  sync_idle_a: assert property (@(negedge SCLK_I) disable iff (!RST_N_I)
    SYNC_N_I |-> bit_cnt == CNT_RESET) else $error("bit counter ran with sync high");

  in_shift_a: assert property (@(negedge SCLK_I) disable iff (!RST_N_I)
    (!SYNC_N_I) |=> in_sr[0] == $past(SDI_I)) else $error("input bit not sampled");

  first_out_a: assert property (@(posedge SCLK_I) disable iff (!RST_N_I)
    (!SYNC_N_I && bit_cnt == CNT_RESET) |=> SDO_O == $past(rd_word[31]))
    else $error("reply did not start with its top bit");

  chain_out_a: assert property (@(posedge SCLK_I) disable iff (!RST_N_I)
    (!SYNC_N_I && bit_cnt == CNT_FULL) |=> SDO_O == $past(in_sr[31]))
    else $error("chain output not the oldest bit");

  reply_word_a: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
    (CE_I && commit && fr.rd) |=> (rd_word[3:0] == 4'h0 && rd_word[31]))
    else $error("reply word malformed");

  code_write_a: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
    (CE_I && wr_code && clr_s2) |=> buffer == $past(fr.data))
    else $error("code write did not reach the buffer");

  cfg_write_a: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
    (CE_I && wr && fr.addr == ADDR_CFG1) |=> cfg1[3:0] == 4'h0)
    else $error("low nibble of configuration kept");

  rate_write_a: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
    (CE_I && wr && fr.addr == ADDR_CFG2) |=> DEGLITCH_RATE_O == $past(in_sr[6:4]))
    else $error("rate field not written");

  chain_latch_a: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
    (CE_I && !mode && chain_dis && ev32_code && !clear_mode && clr_s2 && !swrst
     && !swclr && !wr_code) |=> dac == $past(cap.data))
    else $error("32nd edge update missed");

  clear_load_a: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
    (CE_I && !clr_s2 && !swrst) |=> (dac == $past(clear_code) && clear_mode))
    else $error("clear pin did not load clear code");
  clear_hold_a: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
    (clear_mode && !wr && !swrst) |=> clear_mode)
    else $error("clear mode left without a write");
  sw_clear_a: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
    (CE_I && swclr && !swrst && clr_s2) |=> dac == $past(clear_code))
    else $error("software clear missed");
  strobe_upd_a: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
    (CE_I && mode && upd_rise && !clear_mode && clr_s2 && !swrst && !swclr)
    |=> dac == $past(buffer)) else $error("strobe did not update output");
  async_upd_a: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
    (CE_I && !mode && !chain_dis && wr_code && clr_s2) |=> dac == $past(fr.data))
    else $error("async update at sync rise missed");
  sw_reset_a: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
    (CE_I && swrst) |=> (cfg1 == CFG1_RESET && dac == CODE_RESET))
    else $error("software reset incomplete");
  nop_write_a: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
    (CE_I && wr && fr.addr == ADDR_NOP && clr_s2 && !ev32 && !upd_rise)
    |=> ($stable(cfg1) && $stable(buffer) && $stable(dac)))
    else $error("no-operation write changed state");
  read_cov: cover property (@(posedge SYS_CLK_I) commit && fr.rd);
  chain_cov: cover property (@(posedge SCLK_I) !SYNC_N_I && bit_cnt == CNT_FULL);
  strobe_cov: cover property (@(posedge SYS_CLK_I) mode && upd_rise && !clear_mode);
  clear_cov: cover property (@(posedge SYS_CLK_I) clear_mode ##1 !clear_mode);
  swclr_cov: cover property (@(posedge SYS_CLK_I) swclr);
endmodule

// File: verification/dscp_host.sv
// host serial controller model driving the control port
`timescale 1ns/1ns
module dscp_host (
  output logic      sclk_o,
  output logic      sync_n_o,
  output logic      sdi_o,
  input  wire logic sdo_i
);
  logic [31:0] rx;
  initial begin
    sclk_o   = 1'b0;
    sync_n_o = 1'b1;
    sdi_o    = 1'b0;
    rx       = 32'h0;
  end
  // clock stands still outside frames; bits go out msb first
  task automatic frame(input logic [63:0] w, input int n);
    #13 sync_n_o = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      #3 sdi_o = w[i];
      #4 sclk_o = 1'b1;
      #8 rx = {rx[30:0], sdo_i};
      sclk_o = 1'b0;
    end
    #7 sync_n_o = 1'b1;
    // released line must not keep the last bit
    sdi_o = ~sdi_o;
  endtask
endmodule

// File: verification/dscp_port_bench.sv
// self-checking bench of the serial control port
`timescale 1ns/1ns
module dscp_port_bench;
  import dscp_pkg::*;
  logic        clk, rst_n, strb_n, clr_n, alarm;
  logic        sclk, sync_n, sdi, sdo;
  logic [19:0] code;
  logic        clr_mode, fast, power_down, dgl_dis, cal;
  logic [2:0]  rate;
  int          error_cnt, n_checks, cal_cnt;
  // the start pulse lasts one cycle; count it at the quiet edge
  always @(negedge clk) if (cal === 1'b1) cal_cnt++;
  dscp_host dscp_host_i (.sclk_o(sclk), .sync_n_o(sync_n), .sdi_o(sdi), .sdo_i(sdo));
  dscp_port dscp_port_i (
    .SYS_CLK_I(clk), .RST_N_I(rst_n), .CE_I(1'b1), .SCLK_I(sclk), .SYNC_N_I(sync_n),
    .SDI_I(sdi), .UPDATE_STROBE_N_I(strb_n), .CLEAR_PIN_N_I(clr_n), .ALARM_FLAG_I(alarm),
    .SDO_O(sdo), .DAC_CODE_O(code), .CLEAR_MODE_O(clr_mode), .FAST_OUTPUT_EN_O(fast),
    .POWER_DOWN_O(power_down), .DEGLITCH_DIS_O(dgl_dis), .DEGLITCH_RATE_O(rate), .CAL_START_O(cal)
  );
  initial clk = 1'b0;
  always #50 clk = ~clk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [63:0] w, input int n = 32);
    dscp_host_i.frame(w, n);
    repeat (6) @(negedge clk);
  endtask
  task automatic rd(input logic [31:0] w, input logic [31:0] exp);
    wr(w);
    wr(64'h0);
    chk(dscp_host_i.rx, exp);
  endtask
  task automatic pulse;
    strb_n = 1'b0;
    @(negedge clk);
    strb_n = 1'b1;
    repeat (6) @(negedge clk);
  endtask
  task automatic t_reset;
    chk(code, 32'h0);
    chk({fast, power_down, dgl_dis, rate}, 32'h0);
    rd(32'h82000000, {8'h82, CFG1_RESET});
    $display("reset test done");
  endtask
  task automatic t_sync;
    wr(64'h01123450);
    chk(code, 32'h0);
    pulse();
    chk(code, 32'h12345);
    pulse();
    chk(code, 32'h12345);
    $display("sync update test done");
  endtask
  task automatic t_async;
    wr(64'h02002480);
    chk(fast, 32'h1);
    wr(64'h010abcd0);
    chk(code, 32'h0abcd);
    wr(64'h01fffff0, 31);
    chk(code, 32'h0abcd);
    wr({32'h01fffff0, 32'h01055550}, 64);
    chk(code, 32'h05555);
    chk(dscp_host_i.rx, 32'h01fffff0);
    $display("async and chain test done");
  endtask
  task automatic t_read;
    @(negedge clk);
    alarm = 1'b1;
    rd(32'h81000000, 32'h81055550);
    rd(32'h85000000, 32'h85001000);
    rd(32'h82000000, 32'h82002480);
    $display("readback test done");
  endtask
  task automatic t_clear;
    wr(64'h030aaaa0);
    clr_n = 1'b0;
    repeat (5) @(negedge clk);
    chk({clr_mode, 11'h0, code}, 32'h8000aaaa);
    clr_n = 1'b1;
    repeat (5) @(negedge clk);
    chk(clr_mode, 32'h1);
    wr(64'h01123450);
    chk({clr_mode, 11'h0, code}, 32'h00012345);
    wr(64'h04000020);
    chk(code, 32'h0aaaa);
    wr(64'h00fffff0);
    chk(code, 32'h0aaaa);
    $display("clear test done");
  endtask
  task automatic t_soft_reset;
    wr(64'h060000d0);
    chk({dgl_dis, rate}, 32'hd);
    wr(64'h04000100);
    chk(cal_cnt, 32'h1);
    wr(64'h04000040);
    chk({dgl_dis, rate}, 32'h0);
    chk(code, 32'h0);
    rd(32'h82000000, {8'h82, CFG1_RESET});
    $display("software reset test done");
  endtask
  task automatic stop_test;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    #1000000;
    error_cnt++;
    stop_test();
  end
  initial begin
    rst_n  = 1'b0;
    strb_n = 1'b1;
    clr_n  = 1'b1;
    alarm  = 1'b0;
    cal_cnt = 0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    t_reset();
    t_sync();
    t_async();
    t_read();
    t_clear();
    t_soft_reset();
    stop_test();
  end
endmodule
